// ===== rtl/alarm_low_limit_and_cmd_echo.v
/*
  Serial-side register slice: per-channel low alarm limit bytes and the
  read-only echo of the previously executed command word.
  Assumes the serial pins are synchronous to clk and that the serial
  clock is slow enough for both of its edges to be seen by clk.
  A frame is the time chip select is low; its first 16 rising serial
  clock edges carry the word, MSB first.
*/
`timescale 1ns/1ps
`include "alarm_low_limit_defs.vh"

module alarm_low_limit_and_cmd_echo #(
    parameter NUM_CHANNELS = 8
) (
    input  wire                      clk,
    input  wire                      rst_n,
    input  wire                      serialClk,
    input  wire                      chipSelN,
    input  wire                      serialInLine,
    output reg                       serialOutLine,
    output wire [16*NUM_CHANNELS-1:0] chanLowAlarmLimit,
    output wire [7:0]                commandEcho
);

    // ==================================================================
    // pin history and edge events
    reg        serialClkPrev_q;
    reg        chipSelPrev_q;
    wire       riseEvent;
    wire       fallEvent;
    wire       frameEnd;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            serialClkPrev_q <= 1'b0;
            chipSelPrev_q   <= 1'b1;
        end else begin
            serialClkPrev_q <= serialClk;
            chipSelPrev_q   <= chipSelN;
        end
    end

    assign riseEvent = serialClk & ~serialClkPrev_q & ~chipSelN;
    assign fallEvent = ~serialClk & serialClkPrev_q & ~chipSelN;
    assign frameEnd  = chipSelN & ~chipSelPrev_q;

    // ==================================================================
    // frame counters and input shifter
    reg  [14:0] shiftIn_q;
    reg  [14:0] shiftIn_d;
    reg  [5:0]  riseCnt_q;
    reg  [5:0]  riseCnt_d;
    reg  [5:0]  fallCnt_q;
    reg  [5:0]  fallCnt_d;

    always @* begin
        shiftIn_d = shiftIn_q;
        riseCnt_d = riseCnt_q;
        fallCnt_d = fallCnt_q;
        if (chipSelN) begin
            shiftIn_d = 15'h0000;
            riseCnt_d = 6'h00;
            fallCnt_d = 6'h00;
        end else begin
            if (riseEvent) begin
                shiftIn_d = {shiftIn_q[13:0], serialInLine};
                // counters stop at the top so long frames stay harmless
                if (riseCnt_q != `CNT_SATURATE) begin
                    riseCnt_d = riseCnt_q + 6'h01;
                end
            end
            if (fallEvent && fallCnt_q != `CNT_SATURATE) begin
                fallCnt_d = fallCnt_q + 6'h01;
            end
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shiftIn_q <= 15'h0000;
            riseCnt_q <= 6'h00;
            fallCnt_q <= 6'h00;
        end else begin
            shiftIn_q <= shiftIn_d;
            riseCnt_q <= riseCnt_d;
            fallCnt_q <= fallCnt_d;
        end
    end

    // ==================================================================
    // word decode
    wire [15:0] word;
    wire        wordDone;
    wire        isCommand;
    wire [6:0]  progAddr;
    wire        progWrite;
    wire [7:0]  progData;
    wire        progWriteStrobe;
    wire        progReadStrobe;

    assign word      = {shiftIn_q, serialInLine};
    assign wordDone  = riseEvent && (riseCnt_q == `WORD_LAST_BIT);
    // program accesses carry a 7-bit address with the top bit clear;
    // anything else, and the all-zero word, is an operating command
    assign isCommand = word[`CMD_FLAG_BIT] | (word == `NO_OP_WORD);
    assign progAddr  = word[`ADDR_MSB:`ADDR_LSB];
    assign progWrite = word[`WRITE_FLAG_BIT];
    assign progData  = word[7:0];

    assign progWriteStrobe = wordDone & ~isCommand & progWrite;
    assign progReadStrobe  = wordDone & ~isCommand & ~progWrite;

    // ==================================================================
    // per-channel limit registers
    genvar ch;
    generate
        for (ch = 0; ch < NUM_CHANNELS; ch = ch + 1) begin : gLimit
            localparam [6:0] UPPER_ADDR =
                `ADDR_LL_UPPER_CH0 + ch * `ADDR_CH_STRIDE;
            localparam [6:0] LOWER_ADDR =
                `ADDR_LL_LOWER_CH0 + ch * `ADDR_CH_STRIDE;
            wire writeUpper;
            wire writeLower;

            assign writeUpper = progWriteStrobe &
                                (progAddr == UPPER_ADDR);    // [RL1]
            assign writeLower = progWriteStrobe &
                                (progAddr == LOWER_ADDR);    // [RL2]

            limit_byte_pair uPair (                          // [RL5]
                .clk        (clk),
                .rst_n      (rst_n),
                .writeUpper (writeUpper),
                .writeLower (writeLower),
                .writeData  (progData),
                .limitValue (chanLowAlarmLimit[16*ch +: 16])
            );
        end
    endgenerate

    // ==================================================================
    // command echo state, declared ahead of the read mux that reads it
    reg [7:0] echo_q;
    reg [7:0] echo_d;
    reg [7:0] pendingCmd_q;
    reg [7:0] pendingCmd_d;
    reg       pendingValid_q;
    reg       pendingValid_d;

    // ==================================================================
    // read data selection
    reg [7:0] readData;
    reg [6:0] upperAddr;
    integer   k;

    always @* begin
        readData  = `READ_PAD;
        upperAddr = `ADDR_LL_UPPER_CH0;
        // unmapped addresses, including the other alarm fields, read zero
        for (k = 0; k < NUM_CHANNELS; k = k + 1) begin
            if (progAddr == upperAddr) begin
                readData = chanLowAlarmLimit[16*k+8 +: 8];   // [RL1]
            end
            if (progAddr == upperAddr + 7'h01) begin
                readData = chanLowAlarmLimit[16*k +: 8];     // [RL2]
            end
            upperAddr = upperAddr + `ADDR_CH_STRIDE;
        end
        if (progAddr == `ADDR_CMD_ECHO) begin
            readData = echo_q;                               // [RL6] [RL7]
        end
    end

    // ==================================================================
    // command echo
    always @* begin
        echo_d         = echo_q;
        pendingCmd_d   = pendingCmd_q;
        pendingValid_d = pendingValid_q;
        if (wordDone && isCommand) begin
            pendingCmd_d   = word[15:8];                     // [RL11]
            pendingValid_d = 1'b1;
        end
        // the echo only moves once the frame is over, so a read inside
        // a frame always sees the command of an earlier frame
        if (frameEnd) begin
            if (pendingValid_q) begin
                echo_d = pendingCmd_q;                       // [RL7]
            end
            pendingValid_d = 1'b0;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            echo_q         <= `CMD_ECHO_RESET;               // [RL11]
            pendingCmd_q   <= `CMD_ECHO_RESET;
            pendingValid_q <= 1'b0;
        end else begin
            echo_q         <= echo_d;
            pendingCmd_q   <= pendingCmd_d;
            pendingValid_q <= pendingValid_d;
        end
    end

    assign commandEcho = echo_q;

    // ==================================================================
    // serial output
    reg [15:0] outShift_q;
    reg [15:0] outShift_d;
    reg        serialOut_d;

    always @* begin
        outShift_d  = outShift_q;
        serialOut_d = serialOutLine;
        if (chipSelN) begin
            outShift_d  = 16'h0000;
            serialOut_d = 1'b0;
        end else begin
            if (progReadStrobe) begin
                // data byte first, then eight zero bits
                outShift_d = {readData, `READ_PAD};          // [RL9]
            end
            // the 16th rising edge loads before the 16th falling edge
            if (fallEvent && fallCnt_q >= `ECHO_FIRST_FALL) begin
                serialOut_d = outShift_q[15];                // [RL8]
                outShift_d  = {outShift_q[14:0], 1'b0};      // [RL8]
            end
        end
    end

    // once the sixteen bits are out the line stays low; a host may end
    // the frame any time after the 24th clock without losing anything
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            outShift_q    <= 16'h0000;
            serialOutLine <= 1'b0;
        end else begin
            outShift_q    <= outShift_d;
            serialOutLine <= serialOut_d;                    // [RL10]
        end
    end

endmodule

// ===== rtl/alarm_low_limit_defs.vh
/*
  Constants for the low alarm limit bank and the command echo register:
  register addresses, field positions, reset values and frame counts.
  Assumes it is included by bare name from the design files.
*/
// Functional notes
// RL1: each channel has a read/write upper byte of its low limit; ch0 at 18h.
// RL2: each channel has a read/write lower byte of its low limit; ch0 at 19h.
// RL3: effective limit is upper byte as bits 15:8, lower byte as 7:0.
// RL4: both limit bytes of every channel read zero after reset.
// RL5: limit pair exists for every channel, eight or four by variant.
// RL6: read-only command echo register sits at 3Fh.
// RL7: echo read returns the command executed in the previous frame.
// RL8: echo word leaves on the serial output MSB first from 16th falling edge.
// RL9: first eight bits carry the command, next eight bits are zero.
// RL10: host may stop an echo read after the 24th serial clock.
// RL11: echo holds upper byte of previous command, reads zero after reset.
`ifndef ALARM_LOW_LIMIT_DEFS_VH
`define ALARM_LOW_LIMIT_DEFS_VH

// ==================================================================
// register map
`define ADDR_LL_UPPER_CH0   7'h18
`define ADDR_LL_LOWER_CH0   7'h19
`define ADDR_CH_STRIDE      7'h05
`define ADDR_CMD_ECHO       7'h3F

// ==================================================================
// reset values
`define LL_BYTE_RESET       8'h00
`define CMD_ECHO_RESET      8'h00
`define READ_PAD            8'h00

// ==================================================================
// serial word layout
`define WORD_LAST_BIT       6'h0F
`define ECHO_FIRST_FALL     6'h0F
`define CNT_SATURATE        6'h3F
`define CMD_FLAG_BIT        15
`define ADDR_MSB            15
`define ADDR_LSB            9
`define WRITE_FLAG_BIT      8
`define NO_OP_WORD          16'h0000

`endif

// ===== rtl/limit_byte_pair.v
/*
  One channel's low alarm limit: an upper and a lower byte register
  joined into the 16-bit limit used by the alarm comparator.
  Assumes write strobes are single-cycle pulses in the clk domain.
*/
`timescale 1ns/1ps
`include "alarm_low_limit_defs.vh"

module limit_byte_pair (
    input  wire        clk,
    input  wire        rst_n,
    input  wire        writeUpper,
    input  wire        writeLower,
    input  wire [7:0]  writeData,
    output reg  [15:0] limitValue
);

    // ==================================================================
    // byte registers, stored already joined
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            limitValue <= {`LL_BYTE_RESET, `LL_BYTE_RESET};   // [RL4]
        end else begin
            if (writeUpper) begin
                limitValue[15:8] <= writeData;               // [RL1] [RL3]
            end
            if (writeLower) begin
                limitValue[7:0] <= writeData;                // [RL2] [RL3]
            end
        end
    end

endmodule

// ===== tb/alarm_limit_assertions.sv
/*
  Port checks for the low limit bank and command echo slice.
  Assumes clk sees every serial edge and frames end with serialClk low.
*/
`timescale 1ns/1ps
module alarm_limit_assertions #(
    parameter NUM_CHANNELS = 8
) (
    input wire                       clk,
    input wire                       rst_n,
    input wire                       serialClk,
    input wire                       chipSelN,
    input wire                       serialInLine,
    input wire                       serialOutLine,
    input wire [16*NUM_CHANNELS-1:0] chanLowAlarmLimit,
    input wire [7:0]                 commandEcho
);
    reg        sclk_q;
    reg [5:0]  fallCnt_q;
    reg [15:0] word_q;
    wire       rise = serialClk && !sclk_q && !chipSelN;
    wire       rise16 = rise && fallCnt_q == 6'h0F;
    // ========
    // frame tracking, word kept after the frame ends
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_q    <= 1'b0;
            fallCnt_q <= 6'h00;
            word_q    <= 16'h0000;
        end else begin
            sclk_q <= serialClk;
            if (chipSelN)
                fallCnt_q <= 6'h00;
            else if (!serialClk && sclk_q)
                fallCnt_q <= fallCnt_q + 6'h01;
            if (rise && fallCnt_q < 6'h10)
                word_q <= {word_q[14:0], serialInLine};
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    chk_out_zero: assert property (
        fallCnt_q < 6'h10 || fallCnt_q > 6'h17
        |-> !serialOutLine) else $error("serial out not low");
    chk_echo_bits: assert property (
        !chipSelN && word_q == 16'h7E00
        && fallCnt_q inside {[6'h10:6'h17]}
        |-> serialOutLine == commandEcho[6'h17 - fallCnt_q])
        else $error("echo bit wrong");
    chk_out_steady: assert property (
        (serialClk && !chipSelN) [*3] |-> $stable(serialOutLine))
        else $error("serial out moved while clock high");
    chk_limit_upper: assert property (
        rise16 ##1 word_q[15:8] == 8'h31
        |=> chanLowAlarmLimit[15:8] == word_q[7:0])
        else $error("upper limit byte not written");
    chk_limit_lower: assert property (
        rise16 ##1 word_q[15:8] == 8'h33
        |=> chanLowAlarmLimit[7:0] == word_q[7:0])
        else $error("lower limit byte not written");
    chk_echo_load: assert property (
        $rose(chipSelN) && fallCnt_q > 6'h0F && word_q[15]
        |-> ##[1:2] commandEcho == word_q[15:8])
        else $error("echo not loaded");
    chk_echo_keep: assert property (
        $rose(chipSelN) && (fallCnt_q < 6'h0F
        || (!word_q[15] && word_q != 16'h0000))
        |=> $stable(commandEcho) [*2]) else $error("echo changed");
    chk_reset_clear: assert property (disable iff (1'b0)
        !rst_n && !$past(rst_n) |-> ~|chanLowAlarmLimit
        && commandEcho == 8'h00 && !serialOutLine)
        else $error("state not cleared by reset");
    cover property (rise16 ##1 word_q[15:8] == 8'h33);
    cover property ($rose(chipSelN) && fallCnt_q > 6'h0F && word_q[15]);
    cover property ($past(fallCnt_q) == 6'h17 && word_q == 16'h7E00);
endmodule

bind alarm_low_limit_and_cmd_echo alarm_limit_assertions #(
    .NUM_CHANNELS(NUM_CHANNELS)
) limitChecks (
    .clk(clk),
    .rst_n(rst_n),
    .serialClk(serialClk),
    .chipSelN(chipSelN),
    .serialInLine(serialInLine),
    .serialOutLine(serialOutLine),
    .chanLowAlarmLimit(chanLowAlarmLimit),
    .commandEcho(commandEcho)
);

// ===== tb/host_model.sv
/*
  Host controller on the serial link: one word per frame, MSB first.
  Assumes clk is the system clock; each serial phase lasts 3 clk.
*/
`timescale 1ns/1ps
module host_model (
    input  wire clk,
    output reg  serialClk,
    output reg  chipSelN,
    output reg  serialInLine,
    input  wire serialOutLine
);
    reg [15:0] rxWord;
    event      rxDone;
    initial begin
        serialClk = 1'b0;
        chipSelN = 1'b1;
        serialInLine = 1'b0;
        rxWord = 16'h0000;
    end
    task automatic half;
        repeat (3) @(posedge clk);
        #1;
    endtask
    // ========
    // frame: bits past 24 may be skipped on echo reads
    task automatic frame(input [15:0] word, input integer bits);
        integer i;
        chipSelN = 1'b0;
        rxWord = 16'h0000;
        for (i = 0; i < bits; i = i + 1) begin
            serialInLine = word[15 - i % 16];
            half;
            serialClk = 1'b1;
            if (i >= 16)
                rxWord = {rxWord[14:0], serialOutLine};
            half;
            serialClk = 1'b0;
        end
        half;
        chipSelN = 1'b1;
        // released line shows no stale value
        serialInLine = ~serialInLine;
        -> rxDone;
        half;
    endtask
endmodule

// ===== tb/testbench.sv
/*
  Self-checking bench for the low limit bank and command echo.
  Assumes the host model and the bound checker are compiled with it.
*/
`timescale 1ns/1ps
module testbench;
    localparam NUM = 8;
    reg               clk = 1'b0;
    reg               rst_n = 1'b0;
    wire              serialClk;
    wire              chipSelN;
    wire              serialInLine;
    wire              serialOutLine;
    wire [16*NUM-1:0] limits;
    wire [7:0]        commandEcho;
    reg  [16*NUM-1:0] expLim = {16*NUM{1'b0}};
    reg  [31:0]       seed = 32'h00000022;
    reg  [15:0]       expQ[$];
    reg  [7:0]        echo = 8'h00;
    reg  [6:0]        a;
    integer           failures = 0;
    integer           checked = 0;
    integer           n;
    always #25 clk = ~clk;
    alarm_low_limit_and_cmd_echo #(
        .NUM_CHANNELS(NUM)
    ) dut (
        .clk(clk),
        .rst_n(rst_n),
        .serialClk(serialClk),
        .chipSelN(chipSelN),
        .serialInLine(serialInLine),
        .serialOutLine(serialOutLine),
        .chanLowAlarmLimit(limits),
        .commandEcho(commandEcho)
    );
    host_model host (
        .clk(clk),
        .serialClk(serialClk),
        .chipSelN(chipSelN),
        .serialInLine(serialInLine),
        .serialOutLine(serialOutLine)
    );
    function [31:0] xs(input [31:0] s);
        reg [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        xs = t ^ (t << 5);
    endfunction
    task automatic check(input string what, input [127:0] seen, exp);
        checked = checked + 1;
        if (seen !== exp) begin
            failures = failures + 1;
            $display("mismatch %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic conclude;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // ========
    // driver notes the expected word, the monitor compares it
    task automatic xfer(input [15:0] word, input integer bits, exp);
        expQ.push_back(exp[15:0]);
        host.frame(word, bits);
    endtask
    task automatic rd(input [6:0] adr, input [7:0] exp);
        xfer({adr, 1'b0, 8'h00}, 32, {exp, 8'h00});
    endtask
    task automatic wr(input [6:0] adr, input [7:0] d);
        xfer({adr, 1'b1, d}, 16, 0);
    endtask
    always @(host.rxDone)
        check("serial word", host.rxWord, expQ.pop_front());
    initial begin
        repeat (2) @(posedge clk);
        #1 rst_n = 1'b1;
        rd(7'h3F, 8'h00);
        rd(7'h19, 8'h00);
        check("limits", limits, expLim);
        for (n = 0; n < NUM; n = n + 1) begin
            seed = xs(seed);
            a = 7'h18 + 7'h05 * n[6:0];
            wr(a, seed[15:8]);
            wr(a + 7'h01, seed[7:0]);
            expLim[16*n +: 16] = seed[15:0];
            rd(a, seed[15:8]);
        end
        check("limits", limits, expLim);
        rd(7'h3E, 8'h00);
        for (n = 0; n < 3; n = n + 1) begin
            seed = xs(seed);
            echo = seed[7:0] | 8'h80;
            xfer({echo, seed[15:8]}, 16, 0);
            xfer(16'h7E00, 24, {8'h00, echo});
            rd(7'h3F, echo);
        end
        check("echo", commandEcho, echo);
        wr(7'h3F, 8'h5A);
        xfer(16'hFF00, 8, 0);
        rd(7'h3F, echo);
        @(posedge clk);
        #1 rst_n = 1'b0;
        repeat (2) @(posedge clk);
        #1 rst_n = 1'b1;
        check("limits", limits, 0);
        check("echo", commandEcho, 8'h00);
        conclude;
    end
    initial begin
        #2000000;
        failures = failures + 1;
        conclude;
    end
endmodule
